// file: hdl/regen_stop_pkg.sv
// constants for the regenerative brake selection and stop method logic
package regen_stop_pkg;

    // ========================================================================
    // regenerative function selection codes
    localparam logic [1:0] REGEN_SEL_CONVERTER = 2'h0;
    localparam logic [1:0] REGEN_SEL_HIGH_DUTY = 2'h1;
    localparam logic [1:0] REGEN_SEL_RESTART = 2'h2;

    // ========================================================================
    // brake duty figures, in percent
    localparam logic [7:0] SPECIAL_DUTY_MAX_PCT = 8'h1e;  // 30 %
    localparam logic [7:0] BUILTIN_DUTY_PCT = 8'h02;      // fixed internal limit
    localparam logic [7:0] PREALARM_PCT = 8'h55;          // 85 %
    localparam logic [7:0] FAULT_PCT = 8'h64;             // 100 %

    // ========================================================================
    // terminal function codes
    localparam logic [7:0] OUT_FUNC_PREALARM_POS = 8'h07;  // 7
    localparam logic [7:0] OUT_FUNC_PREALARM_NEG = 8'h6b;  // 107
    localparam logic [7:0] IN_FUNC_OP_ENABLE = 8'h0a;      // 10

    // ========================================================================
    // stop method setting codes (unitless, seconds where a time)
    localparam logic [13:0] STOP_RAMP_FWD_REV = 14'h270f;  // 9999
    localparam logic [13:0] STOP_RAMP_START_DIR = 14'h22b8; // 8888
    localparam logic [13:0] STOP_COAST_MAX = 14'h0064;     // 100
    localparam logic [13:0] STOP_OFFSET_BASE = 14'h03e8;   // 1000
    localparam logic [13:0] STOP_OFFSET_MAX = 14'h044c;    // 1100

    // ========================================================================
    // timing
    localparam int CLK_HZ = 40000000;
    localparam int SECOND_S = 1;
    localparam int CYCLES_PER_SECOND = SECOND_S * CLK_HZ;

    // ========================================================================
    // stop sequencer states, gray along run -> delay -> coast
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_DELAY = 2'b11,
        ST_COAST = 2'b10
    } stop_state_t;

endpackage : regen_stop_pkg

// file: hdl/sync_pair.sv
// two flip-flop synchroniser for a bundle of asynchronous levels
`timescale 1ns/1ps
module sync_pair #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // levels
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta;

    // first stage feeds only the second
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            meta <= '0;
            o_sync <= '0;
        end else begin
            meta <= i_async;
            o_sync <= meta;
        end
    end
endmodule : sync_pair

// file: hdl/regen_brake_and_stop_select.sv
// regenerative brake selection, duty alarms and stop method sequencing
//
// Operation
// - selection 0 ignores special duty setting; fixed built-in duty limit applies
// - selection 1 uses special duty limit, 0 to 30 percent
// - duty at 85 percent of limit raises pre-alarm and panel indicator
// - duty at 100 percent of limit raises regenerative overvoltage fault
// - panel indicator suppressed when selection is 0
// - pre-alarm alone never trips or shuts output off
// - pre-alarm drives terminals coded 7 positive, 107 negative
// - input coded 10 is operation enable; output off while inactive
// - converter ready low coasts motor; on release, restart, with speed search in restart mode only
// - output-shutoff input also blocks output
// - stop settings 9999 or 8888 ramp down when start drops
// - stop setting 0 to 100 s coasts after that delay
// - stop setting 1000 to 1100 coasts after setting minus 1000 seconds
// - delayed coast keeps following frequency command until output shut off
// - running indication drops when motor output stops
// - stop setting disregarded during power-fail, panel, comm-error stop or jog
// - restart while coasting begins at starting frequency unless restart mode is configured
`timescale 1ns/1ps
module regen_brake_and_stop_select
    import regen_stop_pkg::*;
#(
    parameter int N_IN = 5,
    parameter int N_OUT = 3,
    parameter int SEC_CYCLES = CYCLES_PER_SECOND
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // configuration
    input wire logic [1:0] i_regen_function_select,
    input wire logic [7:0] i_special_brake_duty_limit,
    input wire logic [13:0] i_stop_method_select,
    input wire logic [13:0] i_restart_coast_time,
    input wire logic [N_IN*8-1:0] i_input_terminal_function_select,
    input wire logic [N_OUT*8-1:0] i_output_terminal_function_select,
    // brake duty measurement, percent of the 100 % full-scale
    input wire logic [7:0] i_brake_duty,
    // contact inputs (pins, asynchronous)
    input wire logic i_fwd_or_start_input,
    input wire logic i_rev_or_direction_input,
    input wire logic [N_IN-1:0] i_input_terminals,
    input wire logic i_output_shutoff_input,
    // special stop modes active elsewhere in the drive
    input wire logic i_power_fail_stop,
    input wire logic i_panel_stop,
    input wire logic i_comm_error_stop,
    input wire logic i_jog_mode,
    // motor speed feedback
    input wire logic i_motor_stopped,
    // outputs to the modulator
    output logic o_output_enable,
    output logic o_ramp_down,
    output logic o_direction_reverse,
    output logic o_use_starting_frequency,
    output logic o_speed_search,
    // status
    output logic o_running,
    output logic o_brake_duty_panel_indicator,
    output logic o_brake_duty_prealarm_output,
    output logic o_regen_overvoltage_fault,
    output logic [N_OUT-1:0] o_output_terminals
);
    // ========================================================================
    // elaboration checks: refuse sizes the terminal loops and timer cannot serve
    if (N_IN < 1 || N_OUT < 1 || SEC_CYCLES < 1) begin : g_bad_param
        $error("regen_brake_and_stop_select: bad parameter");
    end

    // ========================================================================
    // input synchronisation
    localparam int NSYNC = N_IN + 3;
    logic [NSYNC-1:0] sync_in;
    logic fwd;
    logic rev;
    logic shutoff;
    logic [N_IN-1:0] term;

    sync_pair #(.WIDTH(NSYNC)) u_sync (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_async({i_input_terminals, i_output_shutoff_input,
                  i_rev_or_direction_input, i_fwd_or_start_input}),
        .o_sync(sync_in)
    );

    assign fwd = sync_in[0];
    assign rev = sync_in[1];
    assign shutoff = sync_in[2];
    assign term = sync_in[NSYNC-1:3];

    // ========================================================================
    // brake duty limit and thresholds
    logic [7:0] duty_limit;
    logic [15:0] duty_scaled;
    logic [15:0] prealarm_level;
    logic [15:0] fault_level;
    logic prealarm_hit;
    logic fault_hit;

    // limit selection: converter mode ignores the special setting
    always_comb begin
        if (i_regen_function_select == REGEN_SEL_CONVERTER) begin
            duty_limit = BUILTIN_DUTY_PCT;
        end else if (i_special_brake_duty_limit > SPECIAL_DUTY_MAX_PCT) begin
            duty_limit = SPECIAL_DUTY_MAX_PCT;
        end else begin
            duty_limit = i_special_brake_duty_limit;
        end
    end

    // compare duty*100 against limit*85 and limit*100, avoiding a divider
    assign duty_scaled = 16'(i_brake_duty) * 16'(FAULT_PCT);
    assign prealarm_level = 16'(duty_limit) * 16'(PREALARM_PCT);
    assign fault_level = 16'(duty_limit) * 16'(FAULT_PCT);
    // a zero limit would alarm at once on any duty; treat it as no alarm
    assign prealarm_hit = (duty_limit != 8'h00) && (duty_scaled >= prealarm_level);
    assign fault_hit = (duty_limit != 8'h00) && (duty_scaled >= fault_level);

    // pre-alarm and panel indicator follow the measured level
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_brake_duty_prealarm_output <= 1'b0;
            o_brake_duty_panel_indicator <= 1'b0;
        end else begin
            o_brake_duty_prealarm_output <= prealarm_hit;
            o_brake_duty_panel_indicator <= prealarm_hit &&
                (i_regen_function_select != REGEN_SEL_CONVERTER);
        end
    end

    // overvoltage fault is latched until drive reset
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_regen_overvoltage_fault <= 1'b0;
        end else if (fault_hit) begin
            o_regen_overvoltage_fault <= 1'b1;
        end
    end

    // ========================================================================
    // output terminal mapping of the pre-alarm
    logic [N_OUT-1:0] next_out_terms;

    always_comb begin
        next_out_terms = '0;
        for (int k = 0; k < N_OUT; k++) begin
            if (i_output_terminal_function_select[k*8 +: 8] == OUT_FUNC_PREALARM_POS) begin
                next_out_terms[k] = prealarm_hit;
            end else if (i_output_terminal_function_select[k*8 +: 8] ==
                         OUT_FUNC_PREALARM_NEG) begin
                next_out_terms[k] = !prealarm_hit;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_output_terminals <= '0;
        end else begin
            o_output_terminals <= next_out_terms;
        end
    end

    // ========================================================================
    // operation enable: any input coded 10; absent assignment means enabled
    logic op_enable;
    logic op_assigned;
    logic op_active;

    always_comb begin
        op_assigned = 1'b0;
        op_active = 1'b0;
        for (int k = 0; k < N_IN; k++) begin
            if (i_input_terminal_function_select[k*8 +: 8] == IN_FUNC_OP_ENABLE) begin
                op_assigned = 1'b1;
                op_active = op_active | term[k];
            end
        end
    end

    // converter ready signal is carried on the enable input
    assign op_enable = !op_assigned || op_active;

    // blocked output: enable low or shutoff input high; pre-alarm plays no part
    logic blocked;
    assign blocked = !op_enable || shutoff;

    // speed search after the block clears, only when restart mode is configured
    logic blocked_q;
    logic restart_mode;
    assign restart_mode = (i_regen_function_select == REGEN_SEL_RESTART) &&
                          (i_restart_coast_time != STOP_RAMP_FWD_REV);

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            blocked_q <= 1'b0;
        end else begin
            blocked_q <= blocked;
        end
    end

    // ========================================================================
    // start signal decode by stop method
    logic ramp_method;
    logic delay_offset;
    logic start_dir_style;
    logic start_cmd;
    logic start_q;
    logic reverse_cmd;
    logic special_stop;
    logic [13:0] delay_secs;

    assign ramp_method = (i_stop_method_select == STOP_RAMP_FWD_REV) ||
                         (i_stop_method_select == STOP_RAMP_START_DIR);
    assign delay_offset = (i_stop_method_select >= STOP_OFFSET_BASE) &&
                          (i_stop_method_select <= STOP_OFFSET_MAX);
    assign start_dir_style = (i_stop_method_select == STOP_RAMP_START_DIR) ||
                             delay_offset;
    assign start_cmd = start_dir_style ? fwd : (fwd ^ rev);
    assign reverse_cmd = start_dir_style ? rev : (rev && !fwd);
    assign special_stop = i_power_fail_stop || i_panel_stop ||
                          i_comm_error_stop || i_jog_mode;

    // delay in seconds; out-of-range settings clamp to the 100 s ceiling
    always_comb begin
        if (delay_offset) begin
            delay_secs = i_stop_method_select - STOP_OFFSET_BASE;
        end else if (i_stop_method_select <= STOP_COAST_MAX) begin
            delay_secs = i_stop_method_select;
        end else begin
            delay_secs = STOP_COAST_MAX;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            start_q <= 1'b0;
        end else begin
            start_q <= start_cmd;
        end
    end

    // ========================================================================
    // stop sequencer with a seconds timer
    localparam int SEC_W = $clog2(SEC_CYCLES + 1);
    stop_state_t state;
    stop_state_t next_state;
    logic [SEC_W-1:0] tick_cnt;
    logic [13:0] sec_cnt;
    logic sec_tick;

    assign sec_tick = (tick_cnt == SEC_W'(SEC_CYCLES - 1));

    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE, ST_COAST: begin
                if (start_cmd && !blocked) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (blocked) begin
                    next_state = ST_COAST;
                end else if (!start_cmd && start_q && !special_stop) begin
                    if (ramp_method) begin
                        next_state = ST_IDLE;
                    end else if (delay_secs == 14'h0000) begin
                        next_state = ST_COAST;
                    end else begin
                        next_state = ST_DELAY;
                    end
                end else if (!start_cmd && special_stop) begin
                    next_state = ST_IDLE;
                end
            end
            ST_DELAY: begin
                if (blocked) begin
                    next_state = ST_COAST;
                end else if (start_cmd) begin
                    next_state = ST_RUN;
                end else if (sec_tick && (sec_cnt + 14'h0001 >= delay_secs)) begin
                    next_state = ST_COAST;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // timer restarts at each entry to the delay state
    always_ff @(posedge i_clk) begin
        if (i_rst || state != ST_DELAY) begin
            tick_cnt <= '0;
            sec_cnt <= 14'h0000;
        end else if (sec_tick) begin
            tick_cnt <= '0;
            sec_cnt <= sec_cnt + 14'h0001;
        end else begin
            tick_cnt <= tick_cnt + SEC_W'(1);
        end
    end

    // ========================================================================
    // drive outputs
    logic next_enable;
    assign next_enable = (next_state == ST_RUN) || (next_state == ST_DELAY) ||
                         ((next_state == ST_IDLE) && !i_motor_stopped && !blocked);

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_output_enable <= 1'b0;
            o_ramp_down <= 1'b0;
            o_running <= 1'b0;
            o_direction_reverse <= 1'b0;
            o_use_starting_frequency <= 1'b0;
            o_speed_search <= 1'b0;
        end else begin
            o_output_enable <= next_enable;
            // idle with the motor still turning means a ramp in progress
            o_ramp_down <= (next_state == ST_IDLE) && next_enable;
            o_running <= next_enable;
            if (start_cmd) begin
                o_direction_reverse <= reverse_cmd;
            end
            // fresh start from coast begins at the starting frequency, except in restart mode
            o_use_starting_frequency <= (state == ST_COAST) &&
                                        (next_state == ST_RUN) && !restart_mode;
            o_speed_search <= restart_mode && blocked_q && !blocked &&
                              (state == ST_COAST) && start_cmd;
        end
    end

endmodule : regen_brake_and_stop_select

// file: dv/regen_far_side.sv
// far side model: motor shaft speed and the converter ready line
`timescale 1ns/1ps
module regen_far_side (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // drive outputs and test commands
    input wire logic i_output_enable,
    input wire logic i_ramp_down,
    input wire logic i_power_loss,
    // levels back to the drive
    output logic o_motor_stopped,
    output logic o_converter_ready
);
    logic [3:0] speed;
    // ========================================================================
    // shaft speed: held while driven, decays a step a cycle when ramping or coasting
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            speed <= 4'h0;
        end else if (i_output_enable && !i_ramp_down) begin
            speed <= 4'h8;
        end else if (speed != 4'h0) begin
            speed <= speed - 4'h1;
        end
    end
    assign o_motor_stopped = (speed == 4'h0);
    // ready stays high on the enable terminal while the supply is good
    assign o_converter_ready = !i_power_loss;
endmodule : regen_far_side

// file: dv/regen_brake_and_stop_select_asserts.sv
// port checker for the brake duty alarms and stop sequencing outputs
`timescale 1ns/1ps
module regen_chk
    import regen_stop_pkg::*;
#(
    parameter int N_OUT = 3
) (
    // clock, reset and configuration
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [1:0] i_regen_function_select,
    input wire logic [7:0] i_special_brake_duty_limit,
    input wire logic [7:0] i_brake_duty,
    input wire logic [N_OUT*8-1:0] i_output_terminal_function_select,
    input wire logic i_output_shutoff_input,
    // watched outputs
    input wire logic o_output_enable,
    input wire logic o_running,
    input wire logic o_ramp_down,
    input wire logic o_use_starting_frequency,
    input wire logic o_speed_search,
    input wire logic o_brake_duty_panel_indicator,
    input wire logic o_brake_duty_prealarm_output,
    input wire logic o_regen_overvoltage_fault,
    input wire logic [N_OUT-1:0] o_output_terminals
);
    int lim;
    logic pre_c, flt_c, pre_q, flt_q, pnl_q;
    logic [1:0] rst_hist;
    logic [N_OUT-1:0] term_q;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // ========================================================================
    // effective limit: fixed figure for selection 0, clamped special setting otherwise
    always_comb begin
        lim = int'(i_special_brake_duty_limit);
        if (lim > int'(SPECIAL_DUTY_MAX_PCT)) lim = int'(SPECIAL_DUTY_MAX_PCT);
        if (i_regen_function_select == REGEN_SEL_CONVERTER) lim = int'(BUILTIN_DUTY_PCT);
        pre_c = (lim != 0) && (int'(i_brake_duty) * 100 >= lim * int'(PREALARM_PCT));
        flt_c = (lim != 0) && (int'(i_brake_duty) * 100 >= lim * int'(FAULT_PCT));
    end
    // reference levels one edge behind; history masks the two edges after reset
    always_ff @(posedge i_clk) begin
        rst_hist <= {rst_hist[0], i_rst};
        pre_q <= !i_rst && pre_c;
        flt_q <= !i_rst && flt_c;
        pnl_q <= !i_rst && pre_c && (i_regen_function_select != REGEN_SEL_CONVERTER);
        for (int k = 0; k < N_OUT; k++) begin
            term_q[k] <= !i_rst && ((i_output_terminal_function_select[k*8 +: 8] ==
                OUT_FUNC_PREALARM_POS) ? pre_c : ((i_output_terminal_function_select[k*8 +: 8]
                == OUT_FUNC_PREALARM_NEG) && !pre_c));
        end
    end
    // ========================================================================
    // assertions
    prealarm_level_a: assert property (rst_hist == 2'b00 |->
        o_brake_duty_prealarm_output == pre_q)
        else $error("prealarm level wrong");
    fault_sticky_a: assert property (rst_hist == 2'b00 |->
        o_regen_overvoltage_fault == (flt_q || $past(o_regen_overvoltage_fault)))
        else $error("fault level wrong");
    panel_mask_a: assert property (rst_hist == 2'b00 |->
        o_brake_duty_panel_indicator == pnl_q)
        else $error("panel indicator wrong");
    term_polarity_a: assert property (rst_hist == 2'b00 |-> o_output_terminals == term_q)
        else $error("alarm terminal level wrong");
    running_follows_a: assert property (o_running == o_output_enable)
        else $error("running differs from output enable");
    shutoff_blocks_a: assert property (i_output_shutoff_input [*3] |=> !o_output_enable)
        else $error("output on while shutoff held");
    ramp_while_on_a: assert property (o_ramp_down |-> o_output_enable)
        else $error("ramp without output");
    search_pulse_a: assert property (o_speed_search |=> !o_speed_search)
        else $error("speed search longer than a cycle");
    restart_freq_a: assert property (o_use_starting_frequency |->
        o_output_enable ##1 !o_use_starting_frequency)
        else $error("starting frequency pulse wrong");
    cover property (o_ramp_down);
    cover property (o_speed_search);
    cover property (o_use_starting_frequency);
    cover property (o_regen_overvoltage_fault);
endmodule : regen_chk

bind regen_brake_and_stop_select regen_chk #(.N_OUT(N_OUT)) u_chk (.i_clk, .i_rst,
    .i_regen_function_select, .i_special_brake_duty_limit, .i_brake_duty,
    .i_output_terminal_function_select, .i_output_shutoff_input, .o_output_enable, .o_running,
    .o_ramp_down, .o_use_starting_frequency, .o_speed_search, .o_brake_duty_panel_indicator,
    .o_brake_duty_prealarm_output, .o_regen_overvoltage_fault, .o_output_terminals);

// file: dv/tb.sv
// self-checking testbench for the regenerative brake and stop method block
`timescale 1ns/1ps
module tb
    import regen_stop_pkg::*;
;
    logic i_clk, i_rst, fwd, rev, shut, pl, pf, pnl, cme, jog;
    logic [1:0] sel;
    logic [7:0] lim, duty;
    logic [13:0] stp, rct;
    logic en, rd, dir, usf, ss, run, panel, pre, flt, stopped, ready;
    logic [2:0] term;
    int err_count = 0;
    int n_compared = 0;
    logic [13:0] codes [4] = '{14'h0000, 14'h03ea, 14'h044c, 14'h0064};
    int secs [4] = '{0, 2, 100, 100};
    // ========================================================================
    // one simulated second is ten cycles so the 100 s settings stay short
    regen_brake_and_stop_select #(.SEC_CYCLES(10)) DUT (.i_clk, .i_rst,
        .i_regen_function_select(sel), .i_special_brake_duty_limit(lim),
        .i_stop_method_select(stp), .i_restart_coast_time(rct),
        .i_input_terminal_function_select(40'h000000000a),
        .i_output_terminal_function_select(24'h056b07), .i_brake_duty(duty),
        .i_fwd_or_start_input(fwd), .i_rev_or_direction_input(rev),
        .i_input_terminals({4'h0, ready}), .i_output_shutoff_input(shut),
        .i_power_fail_stop(pf), .i_panel_stop(pnl), .i_comm_error_stop(cme), .i_jog_mode(jog),
        .i_motor_stopped(stopped), .o_output_enable(en), .o_ramp_down(rd),
        .o_direction_reverse(dir), .o_use_starting_frequency(usf), .o_speed_search(ss),
        .o_running(run), .o_brake_duty_panel_indicator(panel),
        .o_brake_duty_prealarm_output(pre), .o_regen_overvoltage_fault(flt),
        .o_output_terminals(term));
    regen_far_side far (.i_clk, .i_rst, .i_output_enable(en), .i_ramp_down(rd),
        .i_power_loss(pl), .o_motor_stopped(stopped), .o_converter_ready(ready));
    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    // ========================================================================
    // helpers: inputs move 2 ns after the edge so sampling never races
    task cyc(input int n);
        repeat (n) @(posedge i_clk);
        #2;
    endtask : cyc
    task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk
    task finish_test;
        $display("errors %0d compares %0d", err_count, n_compared);
        if (err_count == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test
    task rst_dut;
        i_rst = 1'b1;
        {fwd, rev, shut, pl, pf, pnl, cme, jog} = 8'h00;
        sel = REGEN_SEL_HIGH_DUTY;
        lim = 8'h00;
        duty = 8'h00;
        stp = STOP_RAMP_FWD_REV;
        rct = 14'h270f;
        cyc(12);
        i_rst = 1'b0;
        cyc(2);
    endtask : rst_dut
    // ========================================================================
    // scenarios
    task t_ramp;
        rst_dut;
        fwd = 1'b1;
        cyc(3);
        chk(en, 1, "forward start");
        fwd = 1'b0;
        cyc(3);
        chk(rd, 1, "ramp after release");
        chk(en, 1, "output held while ramping");
        cyc(12);
        chk(run, 0, "running off at stop");
    endtask : t_ramp
    task t_dir;
        rst_dut;
        stp = STOP_RAMP_START_DIR;
        rev = 1'b1;
        cyc(4);
        chk(en, 0, "direction alone starts nothing");
        fwd = 1'b1;
        cyc(3);
        chk({en, dir}, 2'b11, "start with reverse direction");
        rst_dut;
        rev = 1'b1;
        cyc(3);
        chk({en, dir}, 2'b11, "reverse start");
    endtask : t_dir
    task t_delay;
        logic lost;
        rst_dut;
        for (int i = 0; i < 4; i++) begin
            stp = codes[i];
            fwd = 1'b1;
            cyc(3);
            chk({en, usf}, {1'b1, i != 0}, "start, from coast at starting frequency");
            fwd = 1'b0;
            if (secs[i] != 0) begin
                cyc(secs[i] * 10 - 2);
                chk({en, rd}, 2'b10, "output follows command in delay");
                cyc(7);
            end else begin
                cyc(3);
            end
            chk(en, 0, "coast after delay");
        end
        stp = 14'h0003;
        fwd = 1'b1;
        cyc(6);
        fwd = 1'b0;
        cyc(10);
        fwd = 1'b1;
        lost = 1'b0;
        repeat (40) begin
            cyc(1);
            if (en !== 1'b1) lost = 1'b1;
        end
        chk(lost, 0, "early return keeps output");
    endtask : t_delay
    task t_special;
        for (int i = 0; i < 4; i++) begin
            rst_dut;
            stp = 14'h0064;
            fwd = 1'b1;
            cyc(4);
            {pf, pnl, cme, jog} = 4'h1 << i;
            fwd = 1'b0;
            cyc(3);
            chk(rd, 1, "special stop ramps");
        end
    endtask : t_special
    task t_block;
        logic seen;
        rst_dut;
        sel = REGEN_SEL_RESTART;
        rct = 14'h0005;
        fwd = 1'b1;
        cyc(4);
        pl = 1'b1;
        cyc(3);
        chk(en, 0, "converter fault coasts");
        pl = 1'b0;
        seen = 1'b0;
        repeat (6) begin
            cyc(1);
            if (ss === 1'b1) seen = 1'b1;
        end
        chk({seen, en}, 2'b11, "speed search and restart");
        shut = 1'b1;
        cyc(3);
        chk(en, 0, "shutoff input blocks");
    endtask : t_block
    task alarm_case(input logic [1:0] s, input logic [7:0] l, input logic [7:0] d,
                    input logic p, input logic f);
        sel = s;
        lim = l;
        duty = d;
        cyc(2);
        chk(pre, p, "prealarm");
        chk(panel, p && (s != REGEN_SEL_CONVERTER), "panel indicator");
        chk(flt, f, "fault");
        chk(term, {1'b0, !p, p}, "alarm terminals");
        if (!f) chk(en, 1, "alarm keeps output on");
    endtask : alarm_case
    task t_alarm;
        rst_dut;
        fwd = 1'b1;
        cyc(4);
        alarm_case(2'h1, 8'h14, 8'h10, 0, 0);
        alarm_case(2'h1, 8'h14, 8'h11, 1, 0);
        alarm_case(2'h1, 8'h28, 8'h1a, 1, 0);
        alarm_case(2'h1, 8'h00, 8'h32, 0, 0);
        alarm_case(2'h0, 8'h14, 8'h01, 0, 0);
        alarm_case(2'h0, 8'h00, 8'h02, 1, 1);
        duty = 8'h00;
        cyc(2);
        chk({flt, pre}, 2'b10, "fault held, prealarm cleared");
    endtask : t_alarm
    // ========================================================================
    // main sequence and watchdog
    initial begin
        t_ramp;
        t_dir;
        t_delay;
        t_special;
        t_block;
        t_alarm;
        finish_test;
    end
    initial begin
        repeat (20000) @(posedge i_clk);
        err_count++;
        finish_test;
    end
endmodule : tb
